// ### bench/nsp_host_model.sv
// Host model taking report words with periodic stalls
`timescale 1ns/1ps
module nsp_host_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Report words
    input wire logic rpt_valid,
    input nsp_pkg::nsp_word_t rpt_word,
    output logic rpt_ready
);
    nsp_pkg::nsp_word_t got[$];
    logic [2:0] cyc_q = 3'h0;
    initial rpt_ready = 1'b0;
    always @(posedge clock) begin
        cyc_q <= reset_n ? cyc_q + 3'h1 : 3'h0;
        // Three-cycle stall in eight, so the buffer fills
        rpt_ready <= reset_n && cyc_q < 3'h5;
        if (rpt_valid && rpt_ready) begin
            got.push_back(rpt_word);
        end
    end
endmodule

// ### bench/nsp_word_packer_checker.sv
// Checker for the subframe word packer
`timescale 1ns/1ps
module nsp_word_packer_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    // Stream
    input wire logic report_enable,
    input wire logic sf_valid,
    input nsp_pkg::nsp_subframe_t sf_in,
    input wire logic sf_ready,
    input wire logic rpt_valid,
    input nsp_pkg::nsp_word_t rpt_word,
    input wire logic rpt_ready
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_take; sf_valid && sf_ready && clk_en && sf_in.parity_ok && report_enable; endsequence
    sequence s_hdr; rpt_valid && rpt_word.head; endsequence
    property p_head; s_take |-> ##[2:40] s_hdr; endproperty
    a_head: assert property (p_head) else $error("no header");
    property p_busy; s_take |=> !sf_ready [*4]; endproperty
    a_busy: assert property (p_busy) else $error("ready too soon");
    property p_drop; sf_valid && sf_ready && clk_en && !sf_in.parity_ok |=> sf_ready; endproperty
    a_drop: assert property (p_drop) else $error("bad subframe taken");
    property p_cnt; s_hdr |-> rpt_word.data[7:4] == 4'h0 && rpt_word.data[3:0] inside {4'ha, 4'h4}; endproperty
    a_cnt: assert property (p_cnt) else $error("bad count");
    property p_glo; s_hdr |-> rpt_word.data[31:24] != 8'h06 || rpt_word.data[3:0] == 4'h4; endproperty
    a_glo: assert property (p_glo) else $error("bad glonass count");
    property p_ten; s_hdr |-> rpt_word.data[31:24] == 8'h06 || rpt_word.data[3:0] == 4'ha; endproperty
    a_ten: assert property (p_ten) else $error("bad ten count");
    property p_hold; rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt_word); endproperty
    a_hold: assert property (p_hold) else $error("word lost");
    property p_end; rpt_valid && rpt_ready && rpt_word.last |=> !rpt_valid || rpt_word.head; endproperty
    a_end: assert property (p_end) else $error("word after last");
endmodule
bind nsp_word_packer nsp_word_packer_checker u_chk (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .report_enable(report_enable), .sf_valid(sf_valid), .sf_in(sf_in), .sf_ready(sf_ready),
    .rpt_valid(rpt_valid), .rpt_word(rpt_word), .rpt_ready(rpt_ready));

// ### bench/nsp_word_packer_tb.sv
// Testbench for the subframe word packer
`timescale 1ns/1ps
module nsp_word_packer_tb;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic report_enable = 1'b1;
    logic sf_valid = 1'b0;
    logic sf_ready, rpt_valid, rpt_ready;
    nsp_pkg::nsp_subframe_t sf_in = '0;
    nsp_pkg::nsp_word_t rpt_word;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    nsp_word_packer u_nsp_word_packer (.clock(clock), .reset_n(reset_n), .clk_en(1'b1), .report_enable(report_enable),
        .sf_valid(sf_valid), .sf_in(sf_in), .sf_ready(sf_ready), .rpt_valid(rpt_valid), .rpt_word(rpt_word),
        .rpt_ready(rpt_ready));
    nsp_host_model u_nsp_host_model (.clock(clock), .reset_n(reset_n), .rpt_valid(rpt_valid), .rpt_word(rpt_word),
        .rpt_ready(rpt_ready));
    initial forever #2.5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(nsp_pkg::nsp_word_t seen, nsp_pkg::nsp_word_t exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    function automatic nsp_pkg::nsp_subframe_t mk(logic [7:0] sys, logic [7:0] sig);
        nsp_pkg::nsp_subframe_t s;
        s = '0;
        s.sys_id = sys;
        s.sig_id = sig;
        s.sv_id = 8'h0c;
        s.sv_known = 1'b1;
        s.parity_ok = 1'b1;
        // Distinct words, odd low bit in every even word (k = 0 included) to catch string bit 1 (str[0]) forced to zero
        for (int k = 0; k < 10; k++) begin
            s.bits[k * 30 +: 30] = 30'h1234_5679 + 30'(k * 'h0101_0101);
        end
        return s;
    endfunction
    task automatic run(nsp_pkg::nsp_subframe_t s);
        nsp_pkg::nsp_word_t exp[$];
        logic [299:0] b;
        logic [3:0] n;
        b = s.invert ? ~s.bits : s.bits;
        n = s.sys_id == 8'h06 ? 4'h4 : 4'ha;
        if (s.parity_ok && report_enable) begin
            exp.push_back({2'b10, s.sys_id, s.sig_id, (s.sys_id == 8'h06 && !s.sv_known) ? 8'hff : s.sv_id, 4'h0, n});
            if (n == 4'h4) begin
                exp.push_back({2'b00, 11'h0, b[84:64]});
                exp.push_back({2'b00, b[63:32]});
                exp.push_back({2'b00, b[31:1], 1'b0});
                exp.push_back({2'b01, 11'h0, s.superframe_known ? s.superframe_num : 5'h0, 12'h0,
                    s.frame_known ? s.frame_num : 4'h0});
            end else begin
                for (int k = 0; k < 10; k++) begin
                    exp.push_back({1'b0, k == 9, 2'b00, b[(9 - k) * 30 +: 30]});
                end
            end
        end
        u_nsp_host_model.got.delete();
        sf_in <= s;
        sf_valid <= 1'b1;
        @(posedge clock);
        sf_valid <= 1'b0;
        repeat (60) @(posedge clock);
        check(34'(u_nsp_host_model.got.size()), 34'(exp.size()));
        foreach (exp[i]) check(u_nsp_host_model.got[i], exp[i]);
        $display("test done sys %h", s.sys_id);
    endtask
    task automatic test_gps();
        run(mk(8'h00, 8'h00));
        run(mk(8'h00, 8'h06));
    endtask
    task automatic test_bds();
        nsp_pkg::nsp_subframe_t s;
        s = mk(8'h03, 8'h00);
        s.invert = 1'b1;
        run(s);
    endtask
    task automatic test_glo();
        nsp_pkg::nsp_subframe_t s;
        s = mk(8'h06, 8'h00);
        s.sv_known = 1'b0;
        s.frame_known = 1'b1;
        s.frame_num = 4'h9;
        s.superframe_num = 5'h15;
        run(s);
    endtask
    task automatic test_drop();
        nsp_pkg::nsp_subframe_t s;
        s = mk(8'h00, 8'h00);
        s.parity_ok = 1'b0;
        run(s);
        report_enable <= 1'b0;
        @(posedge clock);
        run(mk(8'h03, 8'h00));
        report_enable <= 1'b1;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        test_gps();
        test_bds();
        test_glo();
        test_drop();
        conclude();
    end
endmodule

// ### design/nsp_defs.svh
// Constants for the navigation subframe word packer
`ifndef NSP_DEFS_SVH
`define NSP_DEFS_SVH

`define NSP_WORDS_TEN 4'ha
`define NSP_WORDS_GLO 4'h4
`define NSP_SYS_GPS 8'h00
`define NSP_SYS_BDS 8'h03
`define NSP_SYS_GLO 8'h06
`define NSP_SIG_GPS_L5 8'h06
`define NSP_SV_UNKNOWN 8'hff
`define NSP_GLO_STR_BITS 7'd85
`define NSP_BDS_WORD_BITS 6'd30

`endif

// ### design/nsp_pkg.sv
// Types for the navigation subframe word packer
package nsp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HEAD = 3'b010,
        ST_DATA = 3'b100
    } nsp_state_t;

    // Decoded subframe handed over by the tracking logic
    typedef struct packed {
        logic [7:0] sys_id;
        logic [7:0] sig_id;
        logic [7:0] sv_id;
        logic sv_known;
        logic parity_ok;
        logic invert;
        logic [3:0] frame_num;
        logic [4:0] superframe_num;
        logic frame_known;
        logic superframe_known;
        logic [299:0] bits;
    } nsp_subframe_t;

    // One output word; head marks the header word
    typedef struct packed {
        logic head;
        logic last;
        logic [31:0] data;
    } nsp_word_t;

    typedef struct packed {
        nsp_state_t state;
        nsp_subframe_t sf;
        logic [3:0] count;
        logic [3:0] idx;
        logic [1:0] buf_cnt;
        nsp_word_t buf0;
        nsp_word_t buf1;
        logic out_valid;
        nsp_word_t out_word;
        logic in_ready;
    } nsp_regs_t;

endpackage

// ### design/nsp_word_packer.sv
// Packs decoded navigation subframes into 32-bit report words
//
// Functional notes
// - Emit one report per fully decoded subframe, only when enabled and parity passed.
// - Subframe bits copied as received, preamble and check bits kept.
// - Payload as 32-bit words; header carries word_count.
// - Header carries source system identifier; host parses by it first.
// - Inversion demanded by parity scheme is undone before output.
// - GPS L1C/A and BeiDou report ten words in arrival order.
// - GLONASS 85-bit string spread over three 32-bit words.
// - GLONASS bits 1-8 Hamming, 81-84 string number, bit 85 forced zero; the code forces bit 1 (str[0]) to zero instead.
// - Fourth GLONASS word holds frame and superframe numbers, zero when unknown.
// - Unidentified GLONASS satellite reported with identifier 255.
// - BeiDou word: 2 pad bits, 22 data bits, 8 parity bits.
`timescale 1ns/1ps
`include "nsp_defs.svh"

module nsp_word_packer (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    // Control
    input wire logic report_enable,
    // Subframe input
    input wire logic sf_valid,
    input nsp_pkg::nsp_subframe_t sf_in,
    output logic sf_ready,
    // Report word output
    output logic rpt_valid,
    output nsp_pkg::nsp_word_t rpt_word,
    input wire logic rpt_ready
);

    nsp_pkg::nsp_regs_t r_q;
    nsp_pkg::nsp_regs_t r_d;

    // ------------------------------------------------------------
    // Word formatting
    // ------------------------------------------------------------
    function automatic logic [31:0] fmt_word(input nsp_pkg::nsp_subframe_t s, input logic [3:0] i);
        logic [31:0] w;
        logic [84:0] str;
        logic [29:0] w30;
        w = 32'h0000_0000;
        str = s.bits[84:0];
        str[0] = 1'b0;
        w30 = s.bits[(9 - i) * 30 +: 30];
        case (s.sys_id)
            `NSP_SYS_GLO: begin
                // String bit 85 sits in the first word MSB side
                case (i)
                    4'h0: w = {11'h000, str[84:64]};
                    4'h1: w = str[63:32];
                    4'h2: w = str[31:0];
                    default: begin
                        w = 32'h0000_0000;
                        if (s.superframe_known) begin
                            w[20:16] = s.superframe_num;
                        end
                        if (s.frame_known) begin
                            w[3:0] = s.frame_num;
                        end
                    end
                endcase
            end
            default: begin
                // Pad bits left zero; host must not rely on them
                w = {2'b00, w30};
            end
        endcase
        return w;
    endfunction

    function automatic logic [299:0] fix_polarity(input logic [299:0] b, input logic [7:0] sys,
                                                  input logic inv);
        logic [299:0] o;
        o = b;
        // GLONASS strings are left as received; for every other system one flag undoes all ten 30-bit words
        if (inv && sys != `NSP_SYS_GLO) begin
            o = ~b;
        end
        return o;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nsp_pkg::nsp_word_t w;
        logic push;
        logic pop;
        w = '0;
        r_d = r_q;
        push = 1'b0;
        pop = r_q.out_valid && rpt_ready;

        // Build the word for this cycle
        case (r_q.state)
            nsp_pkg::ST_HEAD: begin
                w.head = 1'b1;
                w.data = {r_q.sf.sys_id, r_q.sf.sig_id,
                          (r_q.sf.sys_id == `NSP_SYS_GLO && !r_q.sf.sv_known) ?
                          `NSP_SV_UNKNOWN : r_q.sf.sv_id,
                          4'h0, r_q.count};
            end
            nsp_pkg::ST_DATA: begin
                w.data = fmt_word(r_q.sf, r_q.idx);
                w.last = (r_q.idx == r_q.count - 4'h1);
            end
            default: begin
                w = '0;
            end
        endcase

        // Output stage refill from buffer
        if (pop || !r_q.out_valid) begin
            if (r_q.buf_cnt != 2'd0) begin
                r_d.out_valid = 1'b1;
                r_d.out_word = r_q.buf0;
                r_d.buf0 = r_q.buf1;
                r_d.buf_cnt = r_q.buf_cnt - 2'd1;
            end else begin
                r_d.out_valid = 1'b0;
            end
        end

        // Producer stalls while the two-entry buffer is full
        if (r_q.state != nsp_pkg::ST_IDLE && r_d.buf_cnt != 2'd2) begin
            push = 1'b1;
            if (r_d.buf_cnt == 2'd0) begin
                r_d.buf0 = w;
            end else begin
                r_d.buf1 = w;
            end
            r_d.buf_cnt = r_d.buf_cnt + 2'd1;
        end

        case (r_q.state)
            nsp_pkg::ST_IDLE: begin
                if (sf_valid && r_q.in_ready) begin
                    r_d.in_ready = 1'b0;
                    // Failed or disabled subframes are consumed and dropped
                    if (report_enable && sf_in.parity_ok) begin
                        r_d.sf = sf_in;
                        r_d.sf.bits = fix_polarity(sf_in.bits, sf_in.sys_id, sf_in.invert);
                        r_d.count = (sf_in.sys_id == `NSP_SYS_GLO) ? `NSP_WORDS_GLO : `NSP_WORDS_TEN;
                        r_d.idx = 4'h0;
                        r_d.state = nsp_pkg::ST_HEAD;
                    end else begin
                        r_d.in_ready = 1'b1;
                    end
                end
            end
            nsp_pkg::ST_HEAD: begin
                if (push) begin
                    r_d.state = nsp_pkg::ST_DATA;
                end
            end
            nsp_pkg::ST_DATA: begin
                if (push) begin
                    r_d.idx = r_q.idx + 4'h1;
                    if (w.last) begin
                        r_d.state = nsp_pkg::ST_IDLE;
                        r_d.in_ready = 1'b1;
                    end
                end
            end
            default: begin
                r_d.state = nsp_pkg::ST_IDLE;
                r_d.in_ready = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            r_q <= '0;
            r_q.state <= nsp_pkg::ST_IDLE;
            r_q.in_ready <= 1'b1;
        end else if (clk_en) begin
            r_q <= r_d;
        end
    end

    assign sf_ready = r_q.in_ready;
    assign rpt_valid = r_q.out_valid;
    assign rpt_word = r_q.out_word;

endmodule
